/* serdes_lane_defines.svh */
// Constants for the multi-rate serdes lane control block
`ifndef SERDES_LANE_DEFINES_SVH
`define SERDES_LANE_DEFINES_SVH
// PLL calibration values per rate
`define PLL_CAL_VALUE_1G 8'h3c
`define PLL_CAL_VALUE_2G5 8'h30
// Rotation settings per rate
`define ROT_FREQ_1G 1'h0
`define ROT_DIR_1G 1'h1
`define ROT_ENA_1G 1'h0
`define ROT_FREQ_2G5 1'h1
`define ROT_DIR_2G5 1'h0
`define ROT_ENA_2G5 1'h1
// Integrator time constant range and normal value
`define HYST_MIN_FULL 3'h3
`define HYST_MIN_QUARTER 3'h1
`define HYST_MAX 3'h7
`define HYST_NORMAL 3'h5
// Bandwidth index of the widest offset limit per rate mode
`define BW_FIRST_HALF 3'h3
`define BW_FIRST_QUARTER 3'h2
// Integrator update interval: 128 * 32 * 2^(hyst + 1 - bw) cycles, as exponent
`define TICK_BASE_EXP 5'h0d
`define TICK_CNT_W 21
// Offset compensation limits in ppm, halving per bandwidth step
`define PPM_LIMIT_0 11'h7a1
`define PPM_LIMIT_1 11'h3d1
`define PPM_LIMIT_2 11'h1e8
`define PPM_LIMIT_3 11'h0f4
`define PPM_LIMIT_4 11'h07a
`define PPM_LIMIT_5 11'h03d
`endif

/* serdes_lane_pkg.sv */
// Types shared by the serdes lane control modules
`default_nettype none
package serdes_lane_pkg;
    typedef enum logic [1:0] {RATE_100M, RATE_1G, RATE_2G5, RATE_5G} line_rate_t;
    typedef enum logic [1:0] {ST_HELD, ST_ARMED, ST_CAL, ST_RUN} lane_state_t;
    typedef logic [2:0] cfg3_t;
    typedef logic signed [9:0] phase_step_t;
    typedef logic [10:0] ppm_t;
endpackage
`default_nettype wire

/* phase_reg_if.sv */
// Signals between the lane control and the phase regulator
`timescale 1ns/100ps
`default_nettype none
interface phase_reg_if;
    import serdes_lane_pkg::*;
    logic quarter;
    cfg3_t phs_ctrl;
    cfg3_t hyst;
    cfg3_t bw;
    logic early;
    logic late;
    phase_step_t step;
    logic signed [7:0] integ;
    ppm_t ppm_limit;
    modport ctrl (output quarter, phs_ctrl, hyst, bw, early, late,
        input step, integ, ppm_limit);
    modport reg_side (input quarter, phs_ctrl, hyst, bw, early, late,
        output step, integ, ppm_limit);
endinterface
`default_nettype wire

/* phase_regulator.sv */
// PI phase regulator of the deserializer
`timescale 1ns/100ps
`default_nettype none
`include "serdes_lane_defines.svh"
module phase_regulator (
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_arst_n,
    // Regulator link
    phase_reg_if.reg_side pr
);
    import serdes_lane_pkg::*;

    // Assertion clock and reset
    default clocking reg_cb @(posedge i_mclk);
    endclocking
    default disable iff (!i_arst_n);

    // Offset limit lookup by bandwidth and rate mode
    function automatic ppm_t ppm_lookup(input cfg3_t bw, input logic quarter);
        logic [2:0] first;
        logic [2:0] idx;
        first = quarter ? `BW_FIRST_QUARTER : `BW_FIRST_HALF;
        idx = (bw > first) ? 3'(bw - first) : 3'h0;
        case (idx)
            3'h0: ppm_lookup = `PPM_LIMIT_0;
            3'h1: ppm_lookup = `PPM_LIMIT_1;
            3'h2: ppm_lookup = `PPM_LIMIT_2;
            3'h3: ppm_lookup = `PPM_LIMIT_3;
            3'h4: ppm_lookup = `PPM_LIMIT_4;
            default: ppm_lookup = `PPM_LIMIT_5;
        endcase
    endfunction

    logic [`TICK_CNT_W-1:0] tick_cnt_ff;
    logic signed [7:0] vote_ff;
    logic signed [7:0] integ_ff;
    phase_step_t step_ff;
    ppm_t ppm_ff;

    // Proportional gain and an integrator limit kept below it
    wire [4:0] tick_exp = 5'(`TICK_BASE_EXP + pr.hyst - pr.bw);
    wire [`TICK_CNT_W-1:0] tick_last = `TICK_CNT_W'((22'h1 << tick_exp) - 22'h1);
    wire tick = (tick_cnt_ff >= tick_last); // Shorter interval never overruns the counter
    wire [9:0] prop = 10'(10'h080 >> pr.bw);
    wire [9:0] phs_lim = {5'h0, pr.phs_ctrl, 2'h3};
    wire [9:0] prop_lim = 10'((prop << 2) - 10'h1);
    wire [9:0] int_lim = (phs_lim < prop_lim) ? phs_lim : prop_lim;
    wire signed [9:0] integ_w = 10'(integ_ff);
    wire signed [9:0] lim_s = $signed(int_lim);
    wire int_up = (vote_ff > 8'sh00) && (integ_w < lim_s);
    wire int_dn = (vote_ff < 8'sh00) && (integ_w > -lim_s);
    wire signed [7:0] nxt_integ = integ_ff + (int_up ? 8'sh01 : int_dn ? -8'sh01 : 8'sh00);
    wire vote_up = pr.early && !pr.late && vote_ff != 8'sh7f;
    wire vote_dn = pr.late && !pr.early && vote_ff != -8'sh80;
    wire signed [9:0] p_term = pr.early ? $signed(prop) : pr.late ? -$signed(prop) : 10'sh0;
    wire signed [9:0] nxt_step = p_term + (integ_w >>> 2);

    // Integrator interval, votes and integrator value
    always_ff @(posedge i_mclk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            tick_cnt_ff <= '0;
            vote_ff <= 8'sh00;
            integ_ff <= 8'sh00;
            step_ff <= 10'sh000;
            ppm_ff <= 11'h000;
        end
        else
        begin
            tick_cnt_ff <= tick ? '0 : tick_cnt_ff + 1'b1;
            vote_ff <= tick ? 8'sh00 : vote_ff + (vote_up ? 8'sh01 : vote_dn ? -8'sh01 : 8'sh00);
            integ_ff <= tick ? nxt_integ : integ_ff;
            step_ff <= nxt_step;
            ppm_ff <= ppm_lookup(pr.bw, pr.quarter);
        end
    end

    assign pr.step = step_ff;
    assign pr.integ = integ_ff;
    assign pr.ppm_limit = ppm_ff;

    // Integrator moves one step per interval only
    integ_step_a: assert property (!$past(tick) |-> $stable(integ_ff))
        else $error("integrator moved off tick");
    integ_limit_a: assert property ((integ_w >>> 2) < $signed(10'h080 >> pr.bw)
        || $changed(pr.bw) || $changed(pr.phs_ctrl))
        else $error("integral exceeds proportional");
    cov_tick_c: cover property (tick && int_up);
endmodule
`default_nettype wire

/* serdes_lane_ctrl.sv */
// Control of one multi-rate serdes lane: reset, calibration, loopback, clocks
// Overview of operation
// - Lane runs 100M oversampled, 1G, 2.5G, 5G
// - Lane stays inactive without lane enable
// - Lane held reset until both resets released
// - Equipment loopback feeds serializer into deserializer
// - Facility loopback returns received data to transmitter
// - Recovered clock to local or shared output
// - Squelch recovered clock while PCS lacks data
// - PI regulator, proportional part always stronger
// - Time constant 3-7 full, 1-7 quarter
// - Integrator interval sets cut-off frequency
// - Integrator toggles around offset, residual small
// - Bandwidth field sets proportional gain
// - Offset limits halve per bandwidth step
`timescale 1ns/100ps
`default_nettype none
`include "serdes_lane_defines.svh"
module serdes_lane_ctrl (
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_arst_n,
    // Lane control fields
    input wire logic i_lane_enable,
    input wire logic i_system_reset_n,
    input wire logic i_lane_reset,
    input wire logic i_pll_calibration_enable,
    input wire logic [7:0] i_pll_calibration_value,
    input wire logic i_pll_rotation_frequency,
    input wire logic i_pll_rotation_direction,
    input wire logic i_pll_rotation_enable,
    input wire logic i_quarter_rate_select,
    input wire logic i_half_rate_select,
    input wire logic i_oversample_enable,
    // Loopback and recovered clock fields
    input wire logic i_equipment_loopback_enable,
    input wire logic i_facility_loopback_enable,
    input wire logic i_local_recovered_clock_select,
    input wire logic i_shared_recovered_clock_select,
    input wire logic i_local_clock_squelch_enable,
    input wire logic i_shared_clock_squelch_enable,
    // Phase regulator fields
    input wire serdes_lane_pkg::cfg3_t i_integrator_phase_control,
    input wire serdes_lane_pkg::cfg3_t i_integrator_time_constant,
    input wire serdes_lane_pkg::cfg3_t i_proportional_bandwidth,
    // Analog side
    input wire logic i_pll_locked,
    input wire logic i_tx_data,
    input wire logic i_rx_data,
    input wire logic i_recovered_clk,
    input wire logic i_pcs_data_valid,
    input wire logic i_phase_early,
    input wire logic i_phase_late,
    // Lane status
    output logic o_lane_active,
    output logic o_pll_cal_running,
    output logic o_pll_cal_enable,
    output serdes_lane_pkg::line_rate_t o_line_rate,
    output logic o_config_error,
    // Data paths
    output logic o_line_tx_data,
    output logic o_des_in_data,
    output logic o_input_buffer_bypass,
    output logic o_output_buffer_enable,
    output logic o_ser_phase_align,
    // Recovered clocks
    output logic o_local_reco_clk,
    output logic o_shared_reco_clk,
    output logic o_shared_reco_drive,
    // Phase regulator results
    output serdes_lane_pkg::phase_step_t o_phase_step,
    output logic signed [7:0] o_integrator,
    output serdes_lane_pkg::ppm_t o_offset_limit_ppm
);
    import serdes_lane_pkg::*;

    // Assertion clock and reset
    default clocking lane_cb @(posedge i_mclk);
    endclocking
    default disable iff (!i_arst_n);
    lane_state_t state_ff;
    lane_state_t nxt_state;
    logic active_ff;
    logic cal_run_ff;
    logic cal_ena_ff;
    line_rate_t rate_ff;
    logic err_ff;
    logic tx_ff;
    logic des_ff;
    logic ib_bypass_ff;
    logic ob_ena_ff;
    logic align_ff;
    logic reco_a_ff;
    logic reco_b_ff;
    logic drive_b_ff;

    phase_reg_if pr ();

    // Rate decode from oversample enable and the rate select pair
    function automatic line_rate_t decode_rate(input logic q, input logic h, input logic os);
        if (os)
            decode_rate = RATE_100M;
        else if (q && !h)
            decode_rate = RATE_1G;
        else if (h && !q)
            decode_rate = RATE_2G5;
        else
            decode_rate = RATE_5G;
    endfunction

    // Calibration sequence
    always_comb
    begin
        nxt_state = state_ff;
        unique case (state_ff)
            ST_HELD:
                if (!i_system_reset_n && !i_pll_calibration_enable)
                    nxt_state = ST_ARMED;
            ST_ARMED:
                if (i_system_reset_n && i_pll_calibration_enable)
                    nxt_state = ST_CAL;
            ST_CAL:
                if (!i_system_reset_n)
                    nxt_state = ST_HELD;
                else if (i_pll_locked)
                    nxt_state = ST_RUN;
            ST_RUN:
                if (!i_system_reset_n)
                    nxt_state = ST_HELD;
        endcase
    end

    // Lane activity and configuration checks
    wire line_rate_t nxt_rate = decode_rate(i_quarter_rate_select, i_half_rate_select,
        i_oversample_enable);
    wire nxt_active = (state_ff == ST_RUN) && i_system_reset_n && !i_lane_reset
        && i_lane_enable;
    wire quarter = (nxt_rate == RATE_1G) || (nxt_rate == RATE_100M);
    wire both_loops = i_equipment_loopback_enable && i_facility_loopback_enable;
    wire bad_1g = (nxt_rate == RATE_1G) && (i_pll_calibration_value != `PLL_CAL_VALUE_1G
        || i_pll_rotation_frequency != `ROT_FREQ_1G || i_pll_rotation_direction != `ROT_DIR_1G
        || i_pll_rotation_enable != `ROT_ENA_1G);
    wire bad_2g5 = (nxt_rate == RATE_2G5) && (i_pll_calibration_value != `PLL_CAL_VALUE_2G5
        || i_pll_rotation_frequency != `ROT_FREQ_2G5 || i_pll_rotation_direction != `ROT_DIR_2G5
        || i_pll_rotation_enable != `ROT_ENA_2G5);
    wire [2:0] hyst_min = quarter ? `HYST_MIN_QUARTER : `HYST_MIN_FULL;
    wire hyst_bad = i_integrator_time_constant < hyst_min;
    wire nxt_err = both_loops || bad_1g || bad_2g5 || hyst_bad;
    wire eloop = i_equipment_loopback_enable && !both_loops;
    wire floop = i_facility_loopback_enable && !both_loops;

    // Data path selection, gated by lane activity
    wire nxt_tx = nxt_active && (floop ? i_rx_data : i_tx_data);
    wire nxt_des = nxt_active && (eloop ? i_tx_data : i_rx_data);

    // Recovered clock routing with squelch
    wire reco_ok_a = !(i_local_clock_squelch_enable && !i_pcs_data_valid);
    wire reco_ok_b = !(i_shared_clock_squelch_enable && !i_pcs_data_valid);
    wire nxt_drive_b = nxt_active && i_shared_recovered_clock_select;
    wire nxt_reco_a = nxt_active && i_local_recovered_clock_select && reco_ok_a
        && i_recovered_clk;
    wire nxt_reco_b = nxt_drive_b && reco_ok_b && i_recovered_clk;

    // Regulator configuration, out-of-range time constant raised to its floor
    assign pr.quarter = quarter;
    assign pr.phs_ctrl = i_integrator_phase_control;
    assign pr.hyst = hyst_bad ? hyst_min : i_integrator_time_constant;
    assign pr.bw = i_proportional_bandwidth;
    assign pr.early = nxt_active && i_phase_early;
    assign pr.late = nxt_active && i_phase_late;

    phase_regulator phase_regulator_i (
        .i_mclk (i_mclk),
        .i_arst_n (i_arst_n),
        .pr (pr.reg_side)
    );

    // Lane state and status registers
    always_ff @(posedge i_mclk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            state_ff <= ST_HELD;
            active_ff <= 1'b0;
            cal_run_ff <= 1'b0;
            cal_ena_ff <= 1'b0;
            rate_ff <= RATE_5G;
            err_ff <= 1'b0;
        end
        else
        begin
            state_ff <= nxt_state;
            active_ff <= nxt_active;
            cal_run_ff <= (nxt_state == ST_CAL);
            cal_ena_ff <= i_pll_calibration_enable && (nxt_state != ST_HELD);
            rate_ff <= nxt_rate;
            err_ff <= nxt_err;
        end
    end

    // Data path and clock output registers
    always_ff @(posedge i_mclk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            tx_ff <= 1'b0;
            des_ff <= 1'b0;
            ib_bypass_ff <= 1'b0;
            ob_ena_ff <= 1'b0;
            align_ff <= 1'b0;
            reco_a_ff <= 1'b0;
            reco_b_ff <= 1'b0;
            drive_b_ff <= 1'b0;
        end
        else
        begin
            tx_ff <= nxt_tx;
            des_ff <= nxt_des;
            ib_bypass_ff <= nxt_active && eloop;
            ob_ena_ff <= nxt_active;
            align_ff <= nxt_active && floop;
            reco_a_ff <= nxt_reco_a;
            reco_b_ff <= nxt_reco_b;
            drive_b_ff <= nxt_drive_b;
        end
    end

    assign o_lane_active = active_ff;
    assign o_pll_cal_running = cal_run_ff;
    assign o_pll_cal_enable = cal_ena_ff;
    assign o_line_rate = rate_ff;
    assign o_config_error = err_ff;
    assign o_line_tx_data = tx_ff;
    assign o_des_in_data = des_ff;
    assign o_input_buffer_bypass = ib_bypass_ff;
    assign o_output_buffer_enable = ob_ena_ff;
    assign o_ser_phase_align = align_ff;
    assign o_local_reco_clk = reco_a_ff;
    assign o_shared_reco_clk = reco_b_ff;
    assign o_shared_reco_drive = drive_b_ff;
    assign o_phase_step = pr.step;
    assign o_integrator = pr.integ;
    assign o_offset_limit_ppm = pr.ppm_limit;

    // Checks on the lane behaviour
    lane_enable_gate_a: assert property (
        !i_lane_enable |=> !o_lane_active)
        else $error("lane active without enable");
    lane_reset_hold_a: assert property (
        (!i_system_reset_n || i_lane_reset) |=> !o_lane_active)
        else $error("lane active in reset");
    cal_order_a: assert property (
        $rose(o_pll_cal_running) |-> $past(state_ff) == ST_ARMED)
        else $error("calibration without arm step");
    eloop_path_a: assert property (
        (nxt_active && eloop) |=> o_des_in_data == $past(i_tx_data) && o_input_buffer_bypass
        && o_output_buffer_enable) else $error("equipment loopback path wrong");
    floop_path_a: assert property (
        (nxt_active && floop) |=> o_line_tx_data == $past(i_rx_data) && o_ser_phase_align)
        else $error("facility loopback path wrong");
    loop_excl_a: assert property (
        both_loops |=> o_config_error && !o_input_buffer_bypass && !o_ser_phase_align)
        else $error("both loopbacks not refused");
    squelch_local_a: assert property (
        (i_local_clock_squelch_enable && !i_pcs_data_valid) |=> !o_local_reco_clk)
        else $error("local clock not squelched");
    shared_clk_a: assert property (
        o_shared_reco_clk |-> o_shared_reco_drive && o_lane_active)
        else $error("shared clock without selection");
    cov_run_c: cover property (state_ff == ST_CAL ##1 state_ff == ST_RUN);
    cov_eloop_c: cover property (o_input_buffer_bypass && o_lane_active);
    cov_squelch_c: cover property (o_shared_reco_drive && !o_shared_reco_clk && !i_pcs_data_valid);
endmodule
`default_nettype wire

/* remote_xcvr.sv */
// Model of the remote serial transceiver feeding the lane
`timescale 1ns/100ps
`default_nettype none
module remote_xcvr (
    // Clock and link state
    input wire logic i_mclk,
    input wire logic i_link_on,
    // Line side
    output logic o_rx_data,
    output logic o_reco_clk
);
    logic [3:0] pat_ff = 4'h0;
    logic clk_ff = 1'b0;
    // Data pattern changes every cycle; clock stands still while the link is off
    always @(negedge i_mclk)
    begin
        pat_ff <= {pat_ff[2:0], ~(pat_ff[3] ^ pat_ff[2])};
        clk_ff <= i_link_on ? ~clk_ff : 1'b0;
    end
    // Drive the line outputs
    assign o_rx_data = pat_ff[0];
    assign o_reco_clk = clk_ff;
endmodule
`default_nettype wire

/* serdes_lane_ctrl_bench.sv */
// Self-checking bench for the serdes lane control block
`timescale 1ns/100ps
`default_nettype none
module serdes_lane_ctrl_bench;
    import serdes_lane_pkg::*;
    logic mclk = 1'b0, arst_n = 1'b0, lane_en = 1'b1, system_reset_n_n = 1'b1, lane_rst = 1'b0;
    logic cal_en = 1'b0, ovs = 1'b0, q, h, rot_f, rot_d, rot_e, eloop = 1'b0, floop = 1'b0;
    logic sel_a = 1'b0, sel_b = 1'b0, sq_a = 1'b0, sq_b = 1'b0, locked = 1'b0, tx = 1'b0;
    logic valid = 1'b1, early = 1'b0, late = 1'b0, rx, rclk, rx_s, tx_s, rc_s;
    logic [7:0] cal_val;
    cfg3_t phs = 3'h0, hyst = 3'h5, bw = 3'h3;
    logic active, cal_run, cal_out, cfg_err, line_tx, des_in, ib_byp, ob_en, ph_al;
    logic lclk, sclk, sdrv, e, f;
    line_rate_t rate;
    phase_step_t step, exp_step;
    logic signed [7:0] integ;
    ppm_t ppm;
    ppm_t lim [5] = '{11'h7a1, 11'h3d1, 11'h1e8, 11'h0f4, 11'h07a};
    int fail_count = 0, total_checks = 0;

    // Clock of 5 ns period
    always #2.5 mclk = ~mclk;

    serdes_lane_ctrl serdes_lane_ctrl_i (.i_mclk(mclk), .i_arst_n(arst_n),
        .i_lane_enable(lane_en), .i_system_reset_n(system_reset_n_n), .i_lane_reset(lane_rst),
        .i_pll_calibration_enable(cal_en), .i_pll_calibration_value(cal_val),
        .i_pll_rotation_frequency(rot_f), .i_pll_rotation_direction(rot_d),
        .i_pll_rotation_enable(rot_e), .i_quarter_rate_select(q), .i_half_rate_select(h),
        .i_oversample_enable(ovs), .i_equipment_loopback_enable(eloop),
        .i_facility_loopback_enable(floop), .i_local_recovered_clock_select(sel_a),
        .i_shared_recovered_clock_select(sel_b), .i_local_clock_squelch_enable(sq_a),
        .i_shared_clock_squelch_enable(sq_b), .i_integrator_phase_control(phs),
        .i_integrator_time_constant(hyst), .i_proportional_bandwidth(bw),
        .i_pll_locked(locked), .i_tx_data(tx), .i_rx_data(rx), .i_recovered_clk(rclk),
        .i_pcs_data_valid(valid), .i_phase_early(early), .i_phase_late(late),
        .o_lane_active(active), .o_pll_cal_running(cal_run), .o_pll_cal_enable(cal_out),
        .o_line_rate(rate), .o_config_error(cfg_err), .o_line_tx_data(line_tx),
        .o_des_in_data(des_in), .o_input_buffer_bypass(ib_byp),
        .o_output_buffer_enable(ob_en), .o_ser_phase_align(ph_al),
        .o_local_reco_clk(lclk), .o_shared_reco_clk(sclk), .o_shared_reco_drive(sdrv),
        .o_phase_step(step), .o_integrator(integ), .o_offset_limit_ppm(ppm));

    remote_xcvr remote_xcvr_i (.i_mclk(mclk), .i_link_on(active), .o_rx_data(rx),
        .o_reco_clk(rclk));

    // Compare one value and count it
    task automatic chk(input string nm, input logic [10:0] exp, input logic [10:0] got);
        total_checks++;
        if (got !== exp)
        begin
            $display("Error %s expected %h seen %h", nm, exp, got);
            fail_count++;
        end
    endtask

    // Wait on falling edges
    task automatic tick(input int n);
        repeat (n) @(negedge mclk);
    endtask

    // Capture line inputs at a rising edge, then let outputs settle
    task automatic pe;
        @(posedge mclk);
        rx_s = rx;
        tx_s = tx;
        rc_s = rclk;
        #1;
    endtask

    // Rate, calibration value and rotation set for 1G (0) or 2.5G (1)
    task automatic cfg(input logic g2);
        cal_val = g2 ? 8'h30 : 8'h3c;
        {rot_f, rot_d, rot_e} = g2 ? 3'h5 : 3'h2;
        {q, h} = g2 ? 2'h1 : 2'h2;
    endtask

    // Bounded wait for an integrator value
    task automatic wait_integ(input logic signed [7:0] v, input int lim_n);
        int n;
        n = 0;
        while (integ !== v && n < lim_n)
        begin
            @(negedge mclk);
            n++;
        end
        chk("integrator", v, integ);
    endtask

    // Report and end the run
    task automatic stop_test;
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // Watchdog
    initial
    begin
        #100000;
        fail_count++;
        stop_test;
    end

    // Test sequence
    initial
    begin
        cfg(1'b0);
        tick(16);
        chk("reset rate", 11'h3, rate);
        chk("reset active", 11'h0, active);
        arst_n = 1'b1;
        tick(4);
        chk("held active", 11'h0, active);
        $display("test held done");
        system_reset_n_n = 1'b0;
        tick(1);
        system_reset_n_n = 1'b1;
        cal_en = 1'b1;
        tick(1);
        chk("cal running", 11'h1, cal_run);
        chk("cal enable", 11'h1, cal_out);
        locked = 1'b1;
        tick(2);
        chk("active", 11'h1, active);
        chk("cal done", 11'h0, cal_run);
        chk("out buffer", 11'h1, ob_en);
        chk("cfg ok", 11'h0, cfg_err);
        lane_rst = 1'b1;
        tick(2);
        chk("lane reset", 11'h0, active);
        lane_rst = 1'b0;
        lane_en = 1'b0;
        tick(2);
        chk("disabled", 11'h0, active);
        chk("disabled tx", 11'h0, ob_en);
        lane_en = 1'b1;
        tick(2);
        chk("re-enabled", 11'h1, active);
        $display("test calibration done");
        for (int i = 0; i < 4; i++)
        begin
            {ovs, q, h} = (i == 0) ? 3'h4 : (i == 1) ? 3'h2 : (i == 2) ? 3'h1 : 3'h0;
            tick(2);
            chk("line rate", i[10:0], rate);
        end
        ovs = 1'b0;
        cfg(1'b0);
        cal_val = 8'h30;
        tick(2);
        chk("cal value err", 11'h1, cfg_err);
        cfg(1'b0);
        rot_e = 1'b1;
        tick(2);
        chk("rotation err", 11'h1, cfg_err);
        for (int i = 0; i < 5; i++)
        begin
            cfg(i > 1);
            hyst = (i < 4) ? i[2:0] : 3'h5;
            tick(2);
            chk("time constant", {10'h0, i == 0 || i == 2}, cfg_err);
        end
        cfg(1'b0);
        $display("test config done");
        for (int m = 0; m < 4; m++)
        begin
            tick(1);
            {f, e} = m[1:0];
            {floop, eloop} = m[1:0];
            tick(1);
            repeat (3)
            begin
                @(negedge mclk);
                tx = ~tx;
                pe;
                chk("des in", (e && !f) ? tx_s : rx_s, des_in);
                chk("line tx", (f && !e) ? rx_s : tx_s, line_tx);
                chk("bypass", e && !f, ib_byp);
                chk("phase align", f && !e, ph_al);
                chk("loop err", e && f, cfg_err);
            end
        end
        tick(1);
        {floop, eloop} = 2'h0;
        $display("test loopback done");
        for (int k = 0; k < 8; k++)
        begin
            tick(1);
            {sel_a, sq_a, valid} = {k[2], k[0], k[1]};
            {sel_b, sq_b} = {~k[2], ~k[0]};
            repeat (2)
            begin
                pe;
                chk("local clk", sel_a && !(sq_a && !valid) && rc_s, lclk);
                chk("shared clk", sel_b && !(sq_b && !valid) && rc_s, sclk);
                chk("shared drive", sel_b, sdrv);
            end
        end
        $display("test recovered clock done");
        tick(1);
        for (int b = 2; b < 7; b++)
        begin
            bw = b[2:0];
            for (int v = 0; v < 3; v++)
            begin
                {early, late} = (v == 0) ? 2'h2 : (v == 1) ? 2'h1 : 2'h3;
                exp_step = (v == 1) ? -(10'sd128 >>> b) : 10'sd128 >>> b; // Early wins a tie
                tick(3);
                chk("phase step", exp_step, step);
            end
            chk("ppm quarter", lim[b - 2], ppm);
        end
        cfg(1'b1);
        for (int b = 3; b < 7; b++)
        begin
            bw = b[2:0];
            tick(3);
            chk("ppm half", lim[b - 3], ppm);
        end
        $display("test regulator done");
        cfg(1'b0);
        {hyst, bw, early, late} = {3'h1, 3'h6, 2'h2};
        wait_integ(8'sd3, 1400);
        tick(600);
        chk("integ clamp", 11'h3, integ);
        {early, late} = 2'h1;
        wait_integ(8'sd2, 600);
        $display("test integrator done");
        stop_test;
    end
endmodule
`default_nettype wire
